// >>> core/smp_master.sv
// serial master engine: clock, select timing, shift and receive path
`timescale 1ns/10ps
`default_nettype none
module smp_master (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // configuration
    input wire logic [31:0] global_control_register,
    input wire logic [31:0] format_configuration_register,
    input wire logic [31:0] delay_configuration_register,
    input wire logic select_hold_flag,
    // transmit words
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [15:0] tx_data,
    // received words
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [15:0] rx_data,
    // serial pins
    output logic serial_clock_pin,
    output logic serial_clock_oe,
    output logic master_out_line,
    output logic master_out_oe,
    input wire logic master_in_line,
    output logic chip_select_n,
    // status
    output logic busy
);
    typedef enum logic [1:0] {
        SMP_ST_IDLE = 2'b00,
        SMP_ST_LEAD = 2'b01,
        SMP_ST_SHIFT = 2'b10,
        SMP_ST_TRAIL = 2'b11
    } smp_state_t;

    smp_state_t state;
    smp_state_t next_state;
    smp_pkg::smp_cfg_t cfg;
    smp_pkg::smp_cfg_t next_cfg;
    smp_pkg::smp_cfg_t live;
    logic [9:0] cnt;
    logic [9:0] next_cnt;
    logic [5:0] edges;
    logic [5:0] next_edges;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic [15:0] rxsh;
    logic [15:0] next_rxsh;
    logic [15:0] rx_word;
    logic next_sclk;
    logic next_mosi;
    logic next_cs_n;
    logic next_oe;
    logic next_tx_ready;
    logic next_busy;
    logic master_en;
    logic miso_f;
    logic rx_push;
    logic buf_in_ready;
    logic leading;
    logic [9:0] lead_wait;
    logic [7:0] half_lo;
    logic [7:0] half_hi;

    smp_sync3 u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .pin(master_in_line),
        .level(miso_f)
    );

    // stall by the reader halts new transfers via tx_ready
    smp_buf2 #(
        .WIDTH(smp_pkg::SMP_WORD_W),
        .DEPTH(smp_pkg::SMP_BUF_DEPTH)
    ) u_rxbuf (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(rx_push),
        .in_ready(buf_in_ready),
        .in_data(rx_word),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // live configuration, captured at transfer start so edits never tear a word
    always_comb begin
        master_en = global_control_register[smp_pkg::GCR_MASTER_BIT];
        live.pol = format_configuration_register[smp_pkg::FMT_POL_BIT];
        live.pha = format_configuration_register[smp_pkg::FMT_PHA_BIT];
        live.hold = select_hold_flag;
        live.period = smp_pkg::smp_period(
            format_configuration_register[smp_pkg::FMT_PS_MSB:smp_pkg::FMT_PS_LSB]);
        live.lead = delay_configuration_register[smp_pkg::DLY_LEAD_MSB:smp_pkg::DLY_LEAD_LSB];
        live.trail = delay_configuration_register[smp_pkg::DLY_TRAIL_MSB:smp_pkg::DLY_TRAIL_LSB];
    end

    always_comb begin
        half_lo = smp_pkg::smp_half(cfg.period);
        half_hi = 8'(cfg.period - {1'b0, half_lo});
        lead_wait = {2'b00, smp_pkg::smp_half(live.period)} + {2'b00, live.lead}
            + ((live.pol && live.hold) ? smp_pkg::SMP_LEAD_EXTRA_HOLD : smp_pkg::SMP_LEAD_EXTRA);
        leading = ~edges[0];
        rx_word = cfg.pha ? {rxsh[14:0], miso_f} : rxsh;
    end

    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_cnt = cnt;
        next_edges = edges;
        next_sclk = serial_clock_pin;
        next_mosi = master_out_line;
        next_cs_n = chip_select_n;
        next_shreg = shreg;
        next_rxsh = rxsh;
        rx_push = 1'b0;
        unique case (state)
            SMP_ST_IDLE: begin
                next_sclk = live.pol;
                next_cs_n = 1'b1;
                if (tx_ready && tx_valid) begin
                    next_cfg = live;
                    next_state = SMP_ST_LEAD;
                    next_cs_n = 1'b0;
                    next_edges = 6'h00;
                    // the hop from lead to shift costs one cycle of the wait
                    next_cnt = lead_wait - 10'h002;
                    if (live.pha) begin
                        next_shreg = tx_data;
                    end else begin
                        next_mosi = tx_data[15];
                        next_shreg = {tx_data[14:0], 1'b0};
                    end
                end
            end
            SMP_ST_LEAD: begin
                if (cnt == 10'h000) begin
                    next_state = SMP_ST_SHIFT;
                end else begin
                    next_cnt = cnt - 10'h001;
                end
            end
            SMP_ST_SHIFT: begin
                if (cnt != 10'h000) begin
                    next_cnt = cnt - 10'h001;
                end else begin
                    next_sclk = ~serial_clock_pin;
                    next_edges = edges + 6'h01;
                    next_cnt = {2'b00, (leading ? half_hi : half_lo)} - 10'h001;
                    if (cfg.pha == leading) begin
                        // phase one drives on leading edge, half a period before sampling
                        if (edges != smp_pkg::SMP_LAST_EDGE) begin
                            next_mosi = shreg[15];
                            next_shreg = {shreg[14:0], 1'b0};
                        end
                    end else begin
                        next_rxsh = {rxsh[14:0], miso_f};
                    end
                    if (edges == smp_pkg::SMP_LAST_EDGE) begin
                        rx_push = 1'b1;
                        next_state = SMP_ST_TRAIL;
                        next_cnt = {2'b00, cfg.trail};
                    end
                end
            end
            SMP_ST_TRAIL: begin
                if (cnt == 10'h000) begin
                    next_cs_n = 1'b1;
                    next_state = SMP_ST_IDLE;
                end else begin
                    next_cnt = cnt - 10'h001;
                end
            end
        endcase
        if (!master_en) begin
            // leaving master mode aborts any word in flight
            next_state = SMP_ST_IDLE;
            next_cs_n = 1'b1;
            next_sclk = live.pol;
            rx_push = 1'b0;
        end
        next_oe = master_en;
        next_busy = (next_state != SMP_ST_IDLE);
        // room now and no push now means room stays once idle
        next_tx_ready = master_en && (next_state == SMP_ST_IDLE) && buf_in_ready && !rx_push;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= SMP_ST_IDLE;
            cfg <= '0;
            cnt <= 10'h000;
            edges <= 6'h00;
            shreg <= 16'h0000;
            rxsh <= 16'h0000;
            serial_clock_pin <= 1'b0;
            serial_clock_oe <= 1'b0;
            master_out_line <= 1'b0;
            master_out_oe <= 1'b0;
            chip_select_n <= 1'b1;
            tx_ready <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            cnt <= next_cnt;
            edges <= next_edges;
            shreg <= next_shreg;
            rxsh <= next_rxsh;
            serial_clock_pin <= next_sclk;
            serial_clock_oe <= next_oe;
            master_out_line <= next_mosi;
            master_out_oe <= next_oe;
            chip_select_n <= next_cs_n;
            tx_ready <= next_tx_ready;
            busy <= next_busy;
        end
    end
endmodule // smp_master
`default_nettype wire

// >>> core/smp_pkg.sv
// constants, types and helpers shared by the serial master block
// Overview of operation
// - clock period is prescale plus one bus cycles, never under 25 ns
// - prescale zero gives a two-cycle period, still held to 25 ns
// - prescale sits in format bits 15..8, longest period 256 cycles
// - global bit 0 selects master: drive clock and data out, take data in
// - format bit 16 selects clock phase one behaviour
// - format bit 17 sets clock polarity and hence the active edges
// - clock high and low each last about half the period
// - lead and trail delay counts come from the delay register
// - first edge waits half period plus lead plus 2, or 3 with polarity and hold
// - select stays low trail count plus one cycles after the last edge
// - each out bit leads its sampling edge by half a period and holds after, except the first in phase zero, set when select falls
// - input sampled on falling edge at polarity 0, rising at polarity 1, in phase one; phase zero the reverse
package smp_pkg;
    localparam int SMP_CLK_NS = 8;
    localparam int SMP_MIN_SCLK_NS = 25;
    localparam int SMP_MIN_SCLK_CYC = (SMP_MIN_SCLK_NS + SMP_CLK_NS - 1) / SMP_CLK_NS;
    localparam int GCR_MASTER_BIT = 0;
    localparam int FMT_PS_LSB = 8;
    localparam int FMT_PS_MSB = 15;
    localparam int FMT_PHA_BIT = 16;
    localparam int FMT_POL_BIT = 17;
    localparam int DLY_TRAIL_LSB = 16;
    localparam int DLY_TRAIL_MSB = 23;
    localparam int DLY_LEAD_LSB = 24;
    localparam int DLY_LEAD_MSB = 31;
    localparam int SMP_WORD_W = 16;
    localparam int SMP_BUF_DEPTH = 2;
    localparam logic [5:0] SMP_LAST_EDGE = 6'h1F;
    localparam logic [9:0] SMP_LEAD_EXTRA = 10'h002;
    localparam logic [9:0] SMP_LEAD_EXTRA_HOLD = 10'h003;
    localparam logic [8:0] SMP_PS0_PERIOD = 9'h002;
    localparam logic [8:0] SMP_MIN_PERIOD = 9'(SMP_MIN_SCLK_CYC);

    typedef logic [8:0] smp_period_t;

    typedef struct packed {
        logic pol;
        logic pha;
        logic hold;
        smp_period_t period;
        logic [7:0] lead;
        logic [7:0] trail;
    } smp_cfg_t;

    // period in bus cycles from the prescale field
    function automatic smp_period_t smp_period(input logic [7:0] ps);
        smp_period_t p;
        p = (ps == 8'h00) ? SMP_PS0_PERIOD : ({1'b0, ps} + 9'h001);
        if (p < SMP_MIN_PERIOD) begin
            p = SMP_MIN_PERIOD;
        end
        return p;
    endfunction

    // first half of a period; the second half takes the remainder
    function automatic logic [7:0] smp_half(input smp_period_t p);
        return p[8:1];
    endfunction
endpackage

// >>> core/smp_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module smp_sync3 (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // pin and filtered level
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // s1 feeds only s2 to keep metastability contained
    always_comb begin
        next_level = (s2 == s3) ? s3 : level;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule // smp_sync3
`default_nettype wire

// >>> core/smp_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module smp_buf2 #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] next_count;
    logic next_rd_ptr;
    logic next_wr_ptr;
    logic push;
    logic pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
        next_count = count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            count <= next_count;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
        end
    end

    assign in_ready = (count != 2'(DEPTH));
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
endmodule // smp_buf2
`default_nettype wire

// >>> test/smp_slave.sv
// behavioural serial slave on the far side of the master
`timescale 1ns/10ps
`default_nettype none
module smp_slave (
    // settings from the bench
    input wire logic pol,
    input wire logic slow,
    input wire logic [15:0] word,
    // serial pins and received word
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic [15:0] got
);
    logic [15:0] sh = 16'h0000;
    initial miso = 1'b0;
    initial got = 16'h0000;
    // no pull on the line: once released it shows the inverse of the last bit
    always @(posedge cs_n) miso <= ~miso;
    always @(negedge cs_n) sh = word;
    always @(sclk) begin
        if (!cs_n && sclk !== pol) begin
            miso <= #(slow ? 12 : 1) sh[15];
            sh = {sh[14:0], 1'b0};
        end else if (!cs_n) begin
            got = {got[14:0], mosi};
        end
    end
endmodule // smp_slave
`default_nettype wire

// >>> test/smp_master_chk.sv
// assertion checker for the serial master ports
`timescale 1ns/10ps
`default_nettype none
module smp_master_chk (
    // clock, reset, configuration, handshake
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [31:0] global_control_register,
    input wire logic [31:0] format_configuration_register,
    input wire logic [31:0] delay_configuration_register,
    input wire logic select_hold_flag,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic busy,
    // serial pins
    input wire logic serial_clock_pin,
    input wire logic serial_clock_oe,
    input wire logic master_out_line,
    input wire logic master_out_oe,
    input wire logic chip_select_n
);
    logic [7:0] ps, lead, trail, lo;
    logic [8:0] raw, per;
    logic [9:0] cnt;
    logic [5:0] ecnt;
    logic sclk_q, tog, pol, men;
    assign ps = format_configuration_register[15:8];
    assign pol = format_configuration_register[17];
    assign men = global_control_register[0];
    assign lead = delay_configuration_register[31:24];
    assign trail = delay_configuration_register[23:16];
    assign raw = (ps == 8'h00) ? 9'h002 : {1'b0, ps} + 9'h001;
    assign per = (raw < 9'h004) ? 9'h004 : raw;
    assign lo = per[8:1];
    assign tog = serial_clock_pin != sclk_q;
    // cycles since select fell or since the last clock edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sclk_q <= 1'b0;
            cnt <= 10'h000;
            ecnt <= 6'h00;
        end else begin
            sclk_q <= serial_clock_pin;
            cnt <= chip_select_n ? 10'h000 : (tog ? 10'h001 : cnt + 10'h001);
            ecnt <= chip_select_n ? 6'h00 : ecnt + {5'h00, tog};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_LEAD: assert property (tog && !chip_select_n && ecnt == 6'h00 |->
        cnt == {2'h0, lo} + {2'h0, lead} + 10'h002 + {9'h000, pol & select_hold_flag}) else $error("lead wait wrong");
    AST_HALF: assert property (tog && !chip_select_n && ecnt != 6'h00 |->
        cnt == (ecnt[0] ? {1'b0, per} - {2'h0, lo} : {2'h0, lo})) else $error("half period wrong");
    AST_TRAIL: assert property ($rose(chip_select_n) |->
        ecnt == 6'h20 && cnt == {2'h0, trail} + 10'h001) else $error("trail wait wrong");
    AST_EDGE: assert property (tog && !chip_select_n |->
        serial_clock_pin == (ecnt[0] ? pol : !pol)) else $error("edge direction wrong");
    AST_OUT: assert property (!chip_select_n && !$past(chip_select_n) && $changed(master_out_line)
        && format_configuration_register[16] |-> tog && !ecnt[0]) else $error("data moved off leading edge");
    AST_IDLE: assert property ($past(resetn) && chip_select_n && serial_clock_oe
        && $stable(format_configuration_register) |-> serial_clock_pin == pol) else $error("idle clock level wrong");
    AST_OE: assert property ($past(resetn) |->
        serial_clock_oe == $past(men) && master_out_oe == serial_clock_oe) else $error("enable wrong");
    AST_BUSY: assert property (!chip_select_n |-> busy && !tx_ready) else $error("select without busy");
    AST_START: assert property (tx_valid && tx_ready |=> !chip_select_n && busy) else $error("start missed");
endmodule // smp_master_chk
bind smp_master smp_master_chk chk (.mclk, .resetn, .global_control_register, .format_configuration_register,
    .delay_configuration_register, .select_hold_flag, .tx_valid, .tx_ready, .busy, .serial_clock_pin,
    .serial_clock_oe, .master_out_line, .master_out_oe, .chip_select_n);
`default_nettype wire

// >>> test/smp_master_tb.sv
// self-checking bench for the serial master
`timescale 1ns/10ps
`default_nettype none
module smp_master_tb;
    logic mclk = 1'b0, resetn = 1'b0, hold = 1'b0, slow = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic [31:0] gcr = 32'h0000_0001, fmt = 32'h0001_0F00, dly = 32'h0000_0000;
    logic [15:0] tx_data = 16'h0000, sword = 16'h0000, got, rx_data;
    logic tx_ready, rx_valid, serial_clock_pin, serial_clock_oe, master_out_line, master_out_oe;
    logic master_in_line, chip_select_n, busy;
    int error_cnt = 0, n_checks = 0;
    always #4 mclk = ~mclk;
    smp_master dut (.mclk, .resetn, .global_control_register(gcr), .format_configuration_register(fmt),
        .delay_configuration_register(dly), .select_hold_flag(hold), .tx_valid, .tx_ready, .tx_data,
        .rx_valid, .rx_ready, .rx_data, .serial_clock_pin, .serial_clock_oe, .master_out_line,
        .master_out_oe, .master_in_line, .chip_select_n, .busy);
    smp_slave slave (.pol(fmt[17]), .slow, .word(sword), .sclk(serial_clock_pin), .cs_n(chip_select_n),
        .mosi(master_out_line), .miso(master_in_line), .got);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // every open-ended wait goes through here so a hang ends the run
    task automatic tick(inout int i);
        @(negedge mclk);
        i++;
        if (i > 30000) begin
            check(16'h0000, 16'h0001);
            results();
        end
    endtask
    task automatic send(input logic [15:0] w, input logic [15:0] s);
        int i = 0;
        sword = s;
        tx_data = w;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) tick(i);
        tick(i);
        tx_valid = 1'b0;
        while (chip_select_n !== 1'b1) tick(i);
        check(got, w);
        check({15'h0000, serial_clock_pin}, {15'h0000, fmt[17]});
    endtask
    task automatic pop(input logic [15:0] exp, input logic chk);
        int i = 0;
        while (rx_valid !== 1'b1) tick(i);
        if (chk) check(rx_data, exp);
        rx_ready = 1'b1;
        tick(i);
        rx_ready = 1'b0;
    endtask
    // short prescales leave too little time for the input synchroniser, so received data is not judged there
    task automatic t_modes();
        logic [7:0] ps [7] = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h00, 8'h03, 8'hFF};
        for (int k = 0; k < 7; k++) begin
            fmt = {14'h0000, k[0], 1'b1, ps[k], 8'h00};
            hold = k[1];
            dly = {8'(k * 42), 8'(252 - k * 42), 16'h0000};
            slow = k[0];
            repeat (3) @(negedge mclk);
            send(16'h9C36 ^ 16'(k * 4369), 16'hA5C3 + 16'(k));
            pop(16'hA5C3 + 16'(k), ps[k] > 8'h08);
        end
    endtask
    task automatic t_buffer();
        fmt = 32'h0003_0900;
        dly = 32'h0304_0000;
        repeat (3) @(negedge mclk);
        send(16'h1234, 16'hBEEF);
        send(16'hFEDC, 16'h0F1E);
        tx_valid = 1'b1;
        repeat (60) @(negedge mclk);
        check({14'h0000, tx_ready, chip_select_n}, 16'h0001);
        tx_valid = 1'b0;
        pop(16'hBEEF, 1'b1);
        pop(16'h0F1E, 1'b1);
        check({15'h0000, rx_valid}, 16'h0000);
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        gcr = 32'h0000_0000;
        repeat (3) @(negedge mclk);
        check({13'h0000, serial_clock_oe, master_out_oe, tx_ready}, 16'h0000);
        gcr = 32'h0000_0001;
        repeat (3) @(negedge mclk);
        check({13'h0000, serial_clock_oe, master_out_oe, tx_ready}, 16'h0007);
        t_modes();
        t_buffer();
        results();
    end
endmodule // smp_master_tb
`default_nettype wire
